// [ppl_defines.vh]
// Purpose: Constants for the parallel program loader.
// Assumes: One 250 MHz clock; all strobe pins sampled synchronously.
// Notes: Timing counts are derived from times in nanoseconds.
`ifndef PPL_DEFINES_VH
`define PPL_DEFINES_VH

// ----------------------------------------------------------------
// Strobe actions
// ----------------------------------------------------------------
`define PPL_ACT_ADDR 2'h0
`define PPL_ACT_DATA 2'h1
`define PPL_ACT_CMD 2'h2
`define PPL_ACT_IDLE 2'h3

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define PPL_CMD_NOP 8'h00
`define PPL_CMD_ERASE 8'h80
`define PPL_CMD_WFUSE 8'h40
`define PPL_CMD_WLOCK 8'h20
`define PPL_CMD_WFLASH 8'h10
`define PPL_CMD_WEEP 8'h11
`define PPL_CMD_RSIG 8'h08
`define PPL_CMD_RFUSE 8'h04
`define PPL_CMD_RFLASH 8'h02
`define PPL_CMD_REEP 8'h03

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
`define PPL_FLASH_WORD_MSB 6
`define PPL_FLASH_PAGE_LSB 7
`define PPL_FLASH_ADDR_TOP 15
`define PPL_EEP_BYTE_MSB 2
`define PPL_EEP_PAGE_LSB 3
`define PPL_EEP_ADDR_TOP 11
`define PPL_PAGE_WORDS 128

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPL_CLK_PERIOD_NS 4
`define PPL_ENTRY_HOLD_NS 100
`define PPL_ENTRY_HOLD_CYC ((`PPL_ENTRY_HOLD_NS + `PPL_CLK_PERIOD_NS - 1) / `PPL_CLK_PERIOD_NS)
`define PPL_ENTRY_CLK_PULSES 6
`define PPL_FIFO_DEPTH 8

`endif

// [ppl_fifo.v]
// Purpose: Small synchronous FIFO between page buffer and memory port.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Read data is taken combinationally from the head slot.
`timescale 1ns/10ps

module ppl_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // ppl_fifo

// [ppl_loader.v]
// Purpose: Parallel programming front end: strobes, command, address, page buffer.
// Assumes: All pins synchronous to ref_clk_i; memory port does the real writes.
// Notes: Page writes stream through a FIFO to the memory port.
`timescale 1ns/10ps
`include "ppl_defines.vh"

module ppl_loader (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire hv_entry_i,
  input wire strobe_clock_in_i,
  input wire action_select_hi_i,
  input wire action_select_lo_i,
  input wire byte_select_one_i,
  input wire byte_select_two_i,
  input wire page_latch_strobe_i,
  input wire wr_n_i,
  input wire oe_n_i,
  input wire [7:0] data_i,
  output reg [7:0] data_o,
  output wire data_oe_o,
  output wire ready_flag_o,
  output wire prog_mode_o,
  input wire preserve_eeprom_fuse_i,
  output reg lock_clear_o,
  output wire mem_valid_o,
  input wire mem_ready_i,
  output wire mem_eeprom_o,
  output wire [15:0] mem_addr_o,
  output wire [15:0] mem_wdata_o,
  output reg mem_erase_o,
  output reg mem_erase_eeprom_o,
  input wire mem_erase_done_i,
  input wire [15:0] mem_rdata_i
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_PROG = 3'h1;
  localparam ST_DRAIN = 3'h2;
  localparam ST_ERASE = 3'h3;
  localparam ST_LOCK = 3'h4;
  localparam [6:0] LAST_WORD = 7'h7F;
  localparam [6:0] LAST_EEP = 7'h07;

  function is_cmd;
    input [7:0] cmd;
    input [7:0] code;
    begin
      is_cmd = (cmd == code);
    end
  endfunction

  // ----------------------------------------------------------------
  // Entry detection
  // ----------------------------------------------------------------
  wire [3:0] entry_pins;
  reg [3:0] entry_ref_q;
  reg [2:0] xpulse_q;
  reg [7:0] hold_q;
  reg hv_q;
  reg prog_q;
  reg arm_q;

  assign entry_pins = {page_latch_strobe_i, action_select_hi_i, action_select_lo_i,
                       byte_select_one_i};
  assign prog_mode_o = prog_q;

  reg sclk_q;
  reg wr_n_q;
  reg pl_q;
  wire sclk_rise;
  wire wr_fall;
  wire pl_rise;
  assign sclk_rise = strobe_clock_in_i && !sclk_q;
  assign wr_fall = !wr_n_i && wr_n_q;
  assign pl_rise = page_latch_strobe_i && !pl_q;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
      wr_n_q <= 1'b1;
      pl_q <= 1'b0;
    end else begin
      sclk_q <= strobe_clock_in_i;
      wr_n_q <= wr_n_i;
      pl_q <= page_latch_strobe_i;
    end
  end

  // Clock pulses are counted while high voltage is absent; the pins must
  // then stay at zero for the whole hold window after it appears.
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xpulse_q <= 3'h0;
      hold_q <= 8'h00;
      hv_q <= 1'b0;
      prog_q <= 1'b0;
      arm_q <= 1'b0;
      entry_ref_q <= 4'h0;
    end else begin
      hv_q <= hv_entry_i;
      if (!hv_entry_i) begin
        prog_q <= 1'b0;
        arm_q <= 1'b0;
        if (sclk_rise && xpulse_q != 3'h7) begin
          xpulse_q <= xpulse_q + 3'h1;
        end
      end else if (!hv_q) begin
        arm_q <= (xpulse_q >= `PPL_ENTRY_CLK_PULSES) && (entry_pins == 4'h0);
        entry_ref_q <= entry_pins;
        hold_q <= 8'h00;
        xpulse_q <= 3'h0;
      end else if (arm_q && !prog_q) begin
        if (entry_pins != entry_ref_q) begin
          arm_q <= 1'b0;
        end else if (hold_q == (`PPL_ENTRY_HOLD_CYC - 1)) begin
          prog_q <= 1'b1;
        end else begin
          hold_q <= hold_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Command, address and data latches
  // ----------------------------------------------------------------
  reg [7:0] cmd_q;
  reg [7:0] addr_lo_q;
  reg [7:0] addr_hi_q;
  reg [7:0] dat_lo_q;
  reg [7:0] dat_hi_q;
  reg [2:0] st_q;
  reg [15:0] page_buf [0:`PPL_PAGE_WORDS-1];
  reg [127:0] filled_q;
  reg [6:0] scan_q;
  wire [15:0] addr;
  wire wr_flash;
  wire wr_eep;
  wire busy;

  assign addr = {addr_hi_q, addr_lo_q};
  assign wr_flash = is_cmd(cmd_q, `PPL_CMD_WFLASH);
  assign wr_eep = is_cmd(cmd_q, `PPL_CMD_WEEP);
  assign busy = (st_q != ST_IDLE);
  assign ready_flag_o = prog_q && !busy;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_q <= `PPL_CMD_NOP;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      dat_lo_q <= 8'h00;
      dat_hi_q <= 8'h00;
    end else if (prog_q && sclk_rise) begin
      // Registers keep their value between loads.
      case ({action_select_hi_i, action_select_lo_i})
        `PPL_ACT_ADDR: begin
          if (byte_select_one_i) begin
            addr_hi_q <= data_i;
          end else begin
            addr_lo_q <= data_i;
          end
        end
        `PPL_ACT_DATA: begin
          if (byte_select_one_i) begin
            dat_hi_q <= data_i;
          end else begin
            dat_lo_q <= data_i;
          end
        end
        `PPL_ACT_CMD: begin
          if (!busy) begin
            cmd_q <= data_i;
          end
        end
        default: begin
        end
      endcase
    end
  end

  wire cmd_nop_load;
  assign cmd_nop_load = prog_q && sclk_rise && !busy && action_select_hi_i &&
                        !action_select_lo_i && (data_i == `PPL_CMD_NOP);

  // Page buffer: flash uses index bits 6:0, EEPROM bits 2:0 with the
  // byte in the low half. Fill flags mark which slots will be written.
  wire [6:0] slot;
  assign slot = wr_eep ? {4'h0, addr[`PPL_EEP_BYTE_MSB:0]}
                       : addr[`PPL_FLASH_WORD_MSB:0];

  always @(posedge ref_clk_i) begin
    if (prog_q && pl_rise && (wr_flash || wr_eep) && !busy) begin
      page_buf[slot] <= {dat_hi_q, dat_lo_q};
    end
  end

  // ----------------------------------------------------------------
  // Page write and chip erase sequencer
  // ----------------------------------------------------------------
  wire fifo_in_ready;
  wire [23:0] fifo_out;
  reg [6:0] page_lo_q;
  wire [15:0] wr_addr;
  wire push;
  wire [6:0] scan_last;

  assign scan_last = wr_eep ? LAST_EEP : LAST_WORD;
  // Page number comes from address bits above the word index, which
  // includes the upper bits of the low byte.
  assign wr_addr = wr_eep ? {4'h0, addr[`PPL_EEP_ADDR_TOP:`PPL_EEP_PAGE_LSB], scan_q[2:0]}
                          : {addr[`PPL_FLASH_ADDR_TOP:`PPL_FLASH_PAGE_LSB], scan_q};
  assign push = (st_q == ST_PROG) && filled_q[scan_q];

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ST_IDLE;
      scan_q <= 7'h00;
      filled_q <= 128'h0;
      page_lo_q <= 7'h00;
      mem_erase_o <= 1'b0;
      mem_erase_eeprom_o <= 1'b0;
      lock_clear_o <= 1'b0;
    end else begin
      lock_clear_o <= 1'b0;
      if (!prog_q || cmd_nop_load) begin
        st_q <= ST_IDLE;
        filled_q <= 128'h0;
        mem_erase_o <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (pl_rise && (wr_flash || wr_eep)) begin
              filled_q[slot] <= 1'b1;
            end
            if (wr_fall && is_cmd(cmd_q, `PPL_CMD_ERASE)) begin
              st_q <= ST_ERASE;
              mem_erase_o <= 1'b1;
              mem_erase_eeprom_o <= !preserve_eeprom_fuse_i;
            end else if (wr_fall && !byte_select_one_i && (wr_flash || wr_eep)) begin
              st_q <= ST_PROG;
              scan_q <= 7'h00;
            end
          end
          ST_PROG: begin
            if (!push || fifo_in_ready) begin
              filled_q[scan_q] <= 1'b0;
              if (scan_q == scan_last) begin
                st_q <= ST_DRAIN;
              end else begin
                scan_q <= scan_q + 7'h01;
              end
            end
          end
          ST_DRAIN: begin
            if (!mem_valid_o) begin
              st_q <= ST_IDLE;
            end
          end
          ST_ERASE: begin
            mem_erase_o <= 1'b0;
            if (mem_erase_done_i) begin
              st_q <= ST_LOCK;
            end
          end
          ST_LOCK: begin
            lock_clear_o <= 1'b1;
            st_q <= ST_IDLE;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Only loaded slots are queued, so unlatched words are left untouched.
  ppl_fifo #(
    .WIDTH(24),
    .DEPTH(`PPL_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({wr_eep, wr_addr[6:0], page_buf[scan_q]}),
    .out_valid_o(mem_valid_o),
    .out_ready_i(mem_ready_i),
    .out_data_o(fifo_out)
  );

  // Page number is constant during a write, so only the low bits travel.
  assign mem_eeprom_o = fifo_out[23];
  assign mem_addr_o = wr_eep ? {4'h0, addr[`PPL_EEP_ADDR_TOP:`PPL_EEP_PAGE_LSB], fifo_out[18:16]}
                             : {addr[`PPL_FLASH_ADDR_TOP:`PPL_FLASH_PAGE_LSB], fifo_out[22:16]};
  assign mem_wdata_o = fifo_out[15:0];

  // ----------------------------------------------------------------
  // Read data bus
  // ----------------------------------------------------------------
  assign data_oe_o = prog_q && !oe_n_i;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= 8'h00;
    end else if (is_cmd(cmd_q, `PPL_CMD_RFLASH) || is_cmd(cmd_q, `PPL_CMD_REEP) ||
                 is_cmd(cmd_q, `PPL_CMD_RSIG) || is_cmd(cmd_q, `PPL_CMD_RFUSE)) begin
      data_o <= byte_select_one_i ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
    end else begin
      data_o <= 8'h00;
    end
  end
endmodule // ppl_loader

// [ppl_loader_assertions.sv]
// Purpose: Port-level checks of the parallel program loader.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every ppl_loader instance.
`timescale 1ns/10ps

module ppl_loader_assertions (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire oe_n_i,
  input wire preserve_eeprom_fuse_i,
  input wire mem_erase_done_i,
  input wire data_oe_o,
  input wire ready_flag_o,
  input wire prog_mode_o,
  input wire lock_clear_o,
  input wire mem_valid_o,
  input wire mem_erase_o,
  input wire mem_erase_eeprom_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  chk_oe_drive: assert property (data_oe_o == (prog_mode_o && !oe_n_i))
    else $error("data bus drive does not follow output enable");
  chk_ready_mode: assert property (ready_flag_o |-> prog_mode_o)
    else $error("ready shown outside programming mode");
  chk_idle_quiet: assert property (!prog_mode_o |-> !mem_valid_o && !ready_flag_o)
    else $error("activity outside programming mode");
  chk_erase_busy: assert property (mem_erase_o |=> !ready_flag_o)
    else $error("ready high just after erase start");
  chk_erase_single: assert property (mem_erase_o |=> !mem_erase_o)
    else $error("erase start longer than one cycle");
  chk_eep_select: assert property (mem_erase_o |=> mem_erase_eeprom_o != preserve_eeprom_fuse_i)
    else $error("eeprom erase ignores preserve fuse");
  chk_lock_after: assert property (lock_clear_o |-> $past(mem_erase_done_i, 2))
    else $error("lock clear without finished erase");
  chk_lock_single: assert property (lock_clear_o |=> !lock_clear_o)
    else $error("lock clear longer than one cycle");
  chk_drain_busy: assert property (mem_valid_o |-> !ready_flag_o)
    else $error("ready high while page still draining");
endmodule // ppl_loader_assertions

bind ppl_loader ppl_loader_assertions u_ppl_loader_assertions (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .oe_n_i(oe_n_i),
  .preserve_eeprom_fuse_i(preserve_eeprom_fuse_i), .mem_erase_done_i(mem_erase_done_i),
  .data_oe_o(data_oe_o), .ready_flag_o(ready_flag_o), .prog_mode_o(prog_mode_o),
  .lock_clear_o(lock_clear_o), .mem_valid_o(mem_valid_o), .mem_erase_o(mem_erase_o),
  .mem_erase_eeprom_o(mem_erase_eeprom_o));

// [ppl_mem_model.sv]
// Purpose: Memory port model that logs page writes and finishes erases.
// Assumes: Same clock and reset as the loader.
// Notes: Ready is held low by stall_i so the FIFO can fill up.
`timescale 1ns/10ps

module ppl_mem_model #(
  parameter ERASE_CYC = 20
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire stall_i,
  input wire mem_valid_i,
  input wire mem_eeprom_i,
  input wire [15:0] mem_addr_i,
  input wire [15:0] mem_wdata_i,
  input wire mem_erase_i,
  output reg mem_ready_o,
  output reg mem_erase_done_o
);
  reg [15:0] log_addr [0:15];
  reg [15:0] log_data [0:15];
  reg log_eep [0:15];
  integer n_log;
  integer cnt;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      n_log <= 0;
      cnt <= 0;
      mem_ready_o <= 1'b0;
      mem_erase_done_o <= 1'b0;
    end else begin
      mem_ready_o <= !stall_i;
      if (mem_valid_i && mem_ready_o) begin
        log_addr[n_log[3:0]] <= mem_addr_i;
        log_data[n_log[3:0]] <= mem_wdata_i;
        log_eep[n_log[3:0]] <= mem_eeprom_i;
        n_log <= n_log + 1;
      end
      // A slow erase keeps the loader busy long enough to be seen.
      mem_erase_done_o <= (cnt == 1);
      if (mem_erase_i)
        cnt <= ERASE_CYC;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule // ppl_mem_model

// [tb_top.sv]
// Purpose: Self-checking bench for the parallel program loader.
// Assumes: Pins driven at the falling clock edge.
// Notes: Strobe pulses last two clock cycles.
`timescale 1ns/10ps

module tb_top;
  reg ref_clk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg hv = 1'b0, sclk = 1'b0, xh = 1'b1, xl = 1'b1, bs1 = 1'b0, pl = 1'b0;
  reg wr_n = 1'b1, oe_n = 1'b1, fuse = 1'b1, stall = 1'b0;
  reg [7:0] din = 8'h00;
  reg [15:0] rdata = 16'hA55A;
  wire [7:0] dout;
  wire [15:0] maddr, mwdata;
  wire doe, rdy, pmode, lclr, mvalid, mready, meep, merase, meeep, mdone;
  integer n_fail = 0, compares = 0, n_lclr = 0, i, k;

  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (lclr) n_lclr <= n_lclr + 1;

  ppl_loader u_ppl_loader (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hv_entry_i(hv),
    .strobe_clock_in_i(sclk), .action_select_hi_i(xh), .action_select_lo_i(xl),
    .byte_select_one_i(bs1), .byte_select_two_i(1'b0), .page_latch_strobe_i(pl),
    .wr_n_i(wr_n), .oe_n_i(oe_n), .data_i(din), .data_o(dout), .data_oe_o(doe),
    .ready_flag_o(rdy), .prog_mode_o(pmode), .preserve_eeprom_fuse_i(fuse),
    .lock_clear_o(lclr), .mem_valid_o(mvalid), .mem_ready_i(mready), .mem_eeprom_o(meep),
    .mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_erase_o(merase),
    .mem_erase_eeprom_o(meeep), .mem_erase_done_i(mdone), .mem_rdata_i(rdata));

  ppl_mem_model u_ppl_mem_model (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .stall_i(stall),
    .mem_valid_i(mvalid), .mem_eeprom_i(meep), .mem_addr_i(maddr), .mem_wdata_i(mwdata),
    .mem_erase_i(merase), .mem_ready_o(mready), .mem_erase_done_o(mdone));

  task check(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task close_out;
    begin
      $display("TB: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  task tick(input integer n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task load(input [1:0] act, input b, input [7:0] d);
    begin
      {xh, xl} = act;
      bs1 = b;
      din = d;
      tick(1);
      sclk = 1'b1;
      tick(2);
      sclk = 1'b0;
      {xh, xl} = 2'b11;
      tick(2);
    end
  endtask

  task latch;
    begin
      bs1 = 1'b1;
      pl = 1'b1;
      tick(2);
      pl = 1'b0;
      tick(2);
    end
  endtask

  task wait_ready;
    begin
      i = 0;
      while (rdy !== 1'b1 && i < 2000) begin
        tick(1);
        i = i + 1;
      end
      if (i == 2000) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: ready never returned", $time);
        close_out;
      end
    end
  endtask

  task wr_pulse;
    begin
      bs1 = 1'b0;
      wr_n = 1'b0;
      tick(2);
      wr_n = 1'b1;
      tick(1);
    end
  endtask

  // Entry: six strobe pulses without high voltage, pins low, then high voltage.
  task enter(input bad);
    begin
      hv = 1'b0;
      for (k = 0; k < 6; k = k + 1) load(2'b11, 1'b0, 8'h00);
      {pl, xh, xl, bs1} = 4'h0;
      tick(26);
      hv = 1'b1;
      tick(5);
      xl = bad;
      tick(35);
      xl = 1'b0;
    end
  endtask

  initial begin
    tick(4);
    rstn_i = 1'b1;
    tick(2);
    check(rdy, 1'b0);
    enter(1'b1);
    check(pmode, 1'b0);
    enter(1'b0);
    check(pmode, 1'b1);
    check(rdy, 1'b1);
    $display("test entry done");
    oe_n = 1'b0;
    load(2'b10, 1'b0, 8'h02);
    load(2'b00, 1'b0, 8'h10);
    tick(3);
    check(dout, 8'h5A);
    check(doe, 1'b1);
    bs1 = 1'b1;
    tick(3);
    check(dout, 8'hA5);
    oe_n = 1'b1;
    tick(1);
    check(doe, 1'b0);
    for (k = 0; k < 6; k = k + 1) begin
      load(2'b10, 1'b0, (k < 3) ? (8'h40 >> k) : (8'h08 >> (k - 3)));
      check(rdy, 1'b1);
    end
    load(2'b10, 1'b0, 8'h03);
    $display("test commands done");
    stall = 1'b1;
    load(2'b10, 1'b0, 8'h10);
    load(2'b00, 1'b1, 8'h03);
    for (k = 0; k < 10; k = k + 1) begin
      load(2'b00, 1'b0, 8'h80 + k);
      load(2'b01, 1'b0, k);
      load(2'b01, 1'b1, 8'hC0 + k);
      latch;
    end
    wr_pulse;
    tick(50);
    check(rdy, 1'b0);
    check(u_ppl_mem_model.n_log[15:0], 16'h0000);
    stall = 1'b0;
    wait_ready;
    check(u_ppl_mem_model.n_log[15:0], 16'h000A);
    for (k = 0; k < 10; k = k + 1) begin
      check(u_ppl_mem_model.log_addr[k], 16'h0380 + k);
      check(u_ppl_mem_model.log_data[k], 16'hC000 + (k << 8) + k);
      check(u_ppl_mem_model.log_eep[k], 1'b0);
    end
    $display("test flash page done");
    load(2'b10, 1'b0, 8'h11);
    load(2'b00, 1'b1, 8'h00);
    load(2'b00, 1'b0, 8'h0B);
    load(2'b01, 1'b0, 8'h5C);
    latch;
    wr_pulse;
    wait_ready;
    check(u_ppl_mem_model.n_log[15:0], 16'h000B);
    check(u_ppl_mem_model.log_addr[10], 16'h000B);
    check(u_ppl_mem_model.log_data[10][7:0], 8'h5C);
    check(u_ppl_mem_model.log_eep[10], 1'b1);
    load(2'b00, 1'b0, 8'h0C);
    load(2'b01, 1'b0, 8'h77);
    latch;
    load(2'b10, 1'b0, 8'h00);
    load(2'b10, 1'b0, 8'h11);
    wr_pulse;
    wait_ready;
    tick(10);
    check(u_ppl_mem_model.n_log[15:0], 16'h000B);
    $display("test eeprom and abort done");
    for (k = 0; k < 2; k = k + 1) begin
      fuse = k[0];
      load(2'b10, 1'b0, 8'h80);
      wr_pulse;
      check(rdy, 1'b0);
      check(meeep, !fuse);
      wait_ready;
      tick(1);
      check(n_lclr, k + 1);
    end
    $display("test erase done");
    close_out;
  end
endmodule // tb_top
